// ===== include/exc_pkg.sv
// Exception vectoring constants and carrier types.
// Assumes a single 200 MHz system clock domain.
package exc_pkg;
	localparam int NUM_IRQ      = 44;
	localparam int NUM_EXC      = 60;
	localparam int IRQ_BASE     = 16;
	localparam int PRIO_W       = 3;
	localparam int VEC_W        = 6;
	// Wired lines; reserved lines masked off
	localparam logic [43:0] IRQ_WIRED_MASK = 44'h8_19_FF_FF_C0_FF;
	// Exception numbers
	localparam logic [5:0] EXC_RESET   = 6'h01;
	localparam logic [5:0] EXC_NMI     = 6'h02;
	localparam logic [5:0] EXC_HARD    = 6'h03;
	localparam logic [5:0] EXC_MEM     = 6'h04;
	localparam logic [5:0] EXC_BUS     = 6'h05;
	localparam logic [5:0] EXC_USAGE   = 6'h06;
	localparam logic [5:0] EXC_SVC     = 6'h0B;
	localparam logic [5:0] EXC_DEBUG   = 6'h0C;
	localparam logic [5:0] EXC_PEND_SERVICE = 6'h0E;
	localparam logic [5:0] EXC_TICK    = 6'h0F;
	localparam logic [5:0] EXC_NONE    = 6'h00;
	// Priorities: 5-bit signed, fixed ones negative
	localparam logic signed [4:0] PRI_RESET = -5'sd3;
	localparam logic signed [4:0] PRI_NMI   = -5'sd2;
	localparam logic signed [4:0] PRI_HARD  = -5'sd1;
	localparam logic signed [4:0] PRI_IDLE  = 5'sd8;
	localparam logic [2:0]  PRIO_RESET_VAL  = 3'h0;
	// Vector table base
	localparam logic [31:0] VTOR_RESET = 32'h0000_0000;
	localparam logic [31:0] VTOR_MIN   = 32'h0000_0100;
	localparam logic [31:0] VTOR_MAX   = 32'h3FFF_FF00;
	localparam logic [31:0] VTOR_ALIGN = 32'hFFFF_FF00;
	localparam int VEC_SHIFT = 2;

	// System exception pending bits
	typedef struct packed {
		logic nmi;
		logic hard;
		logic mem;
		logic bus;
		logic usage;
		logic svc;
		logic debug;
		logic pend_service;
		logic tick;
	} sys_pend_t;

	// Winner presented to the core
	typedef struct packed {
		logic                valid;
		logic                preempt;
		logic [5:0]          vector;
		logic signed [4:0]   prio;
		logic [31:0]         addr;
	} winner_t;
endpackage

// ===== logic/exception_priority_vectoring.sv
// Exception priority resolution and handler vector address generation.
// Assumes synchronous level inputs from peripherals and the core.
`timescale 1ns/100ps
module exception_priority_vectoring (
	// Clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	// Peripheral interrupt lines and enables
	input  wire logic [43:0]                  i_irq,
	input  wire logic [43:0]                  i_irq_en,
	// System exception requests from the core
	input  wire exc_pkg::sys_pend_t           i_sys_req,
	// Priority configuration
	input  wire logic                         i_prio_we,
	input  wire logic [5:0]                   i_prio_idx,
	input  wire logic [2:0]                   i_prio_val,
	// Vector table base write
	input  wire logic                         i_base_we,
	input  wire logic                         i_base_priv,
	input  wire logic [31:0]                  i_base_val,
	// Core handshake: entry acknowledge, return
	input  wire logic                         i_take,
	input  wire logic                         i_done,
	// Results
	output logic [43:0]                       o_irq_pend,
	output logic [31:0]                       o_vector_base_offset_reg,
	output exc_pkg::winner_t                  o_win,
	output logic signed [4:0]                 o_running_prio
);
	logic [2:0]         prio_q [exc_pkg::NUM_EXC];
	logic [43:0]        pend_q;
	exc_pkg::sys_pend_t spend_q;
	logic [31:0]        base_q;
	logic signed [4:0]  run_q;
	logic [5:0]         run_vec_q;
	logic [59:0]        cand;
	logic [5:0]         best_v;
	logic signed [4:0]  best_p;
	logic               best_ok;
	exc_pkg::sys_pend_t sclr;
	logic [43:0]        irq_clr;
	logic               base_ok;

	// Timing notes for users of this block:
	// - a request is latched on the edge that samples it, and the
	//   registered winner follows one edge after that;
	// - the core must only take while the winner is valid, and the
	//   winner it sees is one cycle old, so it should leave a gap of a
	//   few cycles between takes;
	// - a return drops the running priority straight to idle, so
	//   nested handlers are not tracked here;
	// - a request and a take of the same source in one cycle leave the
	//   source pending, so no edge is ever lost.

	// Programmable priorities, reset to zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int k = 0; k < exc_pkg::NUM_EXC; k++) begin
				prio_q[k] <= exc_pkg::PRIO_RESET_VAL;
			end
		end else if (i_prio_we && i_prio_idx > exc_pkg::EXC_HARD &&
			i_prio_idx < 6'(exc_pkg::NUM_EXC)) begin
			prio_q[i_prio_idx] <= i_prio_val;
		end
	end

	// Peripheral line released by the current take
	always_comb begin
		irq_clr = '0;
		for (int n = 0; n < exc_pkg::NUM_IRQ; n++) begin
			irq_clr[n] = i_take &&
				o_win.vector == 6'(exc_pkg::IRQ_BASE + n);
		end
	end

	// Peripheral pending latches; new request wins over take
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_q <= '0;
		end else begin
			for (int n = 0; n < exc_pkg::NUM_IRQ; n++) begin
				if (i_irq[n] && exc_pkg::IRQ_WIRED_MASK[n]) begin
					pend_q[n] <= 1'b1;
				end else if (irq_clr[n]) begin
					pend_q[n] <= 1'b0;
				end
			end
		end
	end

	// System exception released by the current take
	always_comb begin
		sclr = '0;
		if (i_take) begin
			unique case (o_win.vector)
				exc_pkg::EXC_NMI:          sclr.nmi          = 1'b1;
				exc_pkg::EXC_HARD:         sclr.hard         = 1'b1;
				exc_pkg::EXC_MEM:          sclr.mem          = 1'b1;
				exc_pkg::EXC_BUS:          sclr.bus          = 1'b1;
				exc_pkg::EXC_USAGE:        sclr.usage        = 1'b1;
				exc_pkg::EXC_SVC:          sclr.svc          = 1'b1;
				exc_pkg::EXC_DEBUG:        sclr.debug        = 1'b1;
				exc_pkg::EXC_PEND_SERVICE: sclr.pend_service = 1'b1;
				exc_pkg::EXC_TICK:         sclr.tick         = 1'b1;
				default: ;
			endcase
		end
	end

	// System exception pending latches; a new request wins per bit
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			spend_q <= '0;
		end else begin
			spend_q <= (spend_q & ~sclr) | i_sys_req;
		end
	end

	// Base write is legal only when privileged and in range once aligned down
	always_comb begin
		base_ok = i_base_we && i_base_priv &&
			(i_base_val & exc_pkg::VTOR_ALIGN) >= exc_pkg::VTOR_MIN &&
			(i_base_val & exc_pkg::VTOR_ALIGN) <= exc_pkg::VTOR_MAX;
	end

	// Vector table base register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			base_q <= exc_pkg::VTOR_RESET;
		end else if (base_ok) begin
			base_q <= i_base_val & exc_pkg::VTOR_ALIGN;
		end
	end

	// Running handler priority; idle is below every priority
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_q     <= exc_pkg::PRI_IDLE;
			run_vec_q <= exc_pkg::EXC_NONE;
		end else if (i_take && o_win.valid) begin
			run_q     <= o_win.prio;
			run_vec_q <= o_win.vector;
		end else if (i_done) begin
			run_q     <= exc_pkg::PRI_IDLE;
			run_vec_q <= exc_pkg::EXC_NONE;
		end
	end

	// Candidate list indexed by exception number
	always_comb begin
		cand = '0;
		cand[exc_pkg::EXC_NMI]    = spend_q.nmi;
		cand[exc_pkg::EXC_HARD]   = spend_q.hard;
		cand[exc_pkg::EXC_MEM]    = spend_q.mem;
		cand[exc_pkg::EXC_BUS]    = spend_q.bus;
		cand[exc_pkg::EXC_USAGE]  = spend_q.usage;
		cand[exc_pkg::EXC_SVC]    = spend_q.svc;
		cand[exc_pkg::EXC_DEBUG]  = spend_q.debug;
		cand[exc_pkg::EXC_PEND_SERVICE] = spend_q.pend_service;
		cand[exc_pkg::EXC_TICK]   = spend_q.tick;
		cand[59:16] = pend_q & i_irq_en;
	end

	// Lowest priority value, then lowest number
	always_comb begin
		logic signed [4:0] p;
		p       = '0;
		best_v  = exc_pkg::EXC_NONE;
		best_p  = exc_pkg::PRI_IDLE;
		best_ok = 1'b0;
		for (int e = 2; e < exc_pkg::NUM_EXC; e++) begin
			if (e == 2) p = exc_pkg::PRI_NMI;
			else if (e == 3) p = exc_pkg::PRI_HARD;
			else p = $signed({2'b00, prio_q[e]});
			if (cand[e] && (!best_ok || p < best_p)) begin
				best_ok = 1'b1;
				best_p  = p;
				best_v  = 6'(e);
			end
		end
	end

	// Registered outputs, refreshed each cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_win                    <= '0;
			o_irq_pend               <= '0;
			o_vector_base_offset_reg <= exc_pkg::VTOR_RESET;
			o_running_prio           <= exc_pkg::PRI_IDLE;
		end else begin
			o_win.valid   <= best_ok;
			o_win.preempt <= best_ok && best_p < run_q;
			o_win.vector  <= best_v;
			o_win.prio    <= best_p;
			o_win.addr    <= base_q + {24'h0, best_v, 2'b00};
			o_irq_pend               <= pend_q;
			o_vector_base_offset_reg <= base_q;
			o_running_prio           <= run_q;
		end
	end
endmodule

// ===== bench/exception_priority_vectoring_monitor.sv
// Checker for the arbiter's winner, pending and base outputs.
// Bound onto the arbiter top; one clock domain.
`timescale 1ns/100ps
module exception_priority_vectoring_monitor (
	input wire logic                    i_clk, i_rst, i_take,
	input wire logic [43:0]             i_irq, o_irq_pend,
	input wire logic [31:0]             o_vector_base_offset_reg,
	input wire exc_pkg::winner_t        o_win,
	input wire logic signed [4:0]       o_running_prio
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic [31:0] vb = o_vector_base_offset_reg;
	// Output relations
	chk_addr_calc: assert property (
		o_win.valid && $stable(vb) |-> o_win.addr == vb + {o_win.vector, 2'b00})
		else $error("winner address wrong");
	chk_base_align: assert property (vb[7:0] == 8'h00)
		else $error("base not aligned");
	chk_base_range: assert property (
		vb == 32'h0 || (vb >= 32'h0000_0100 && vb <= 32'h3FFF_FF00))
		else $error("base out of range");
	chk_base_reset: assert property ($fell(i_rst) |-> vb == 32'h0)
		else $error("base not zero after reset");
	chk_rsv_quiet: assert property (
		(o_irq_pend & ~exc_pkg::IRQ_WIRED_MASK) == 44'h0)
		else $error("reserved line pending");
	chk_pend_latch: assert property (i_irq[0] |-> ##2 o_irq_pend[0])
		else $error("line zero not pending");
	chk_preempt_strict: assert property (
		o_win.valid && $stable(o_running_prio)
		|-> o_win.preempt == (o_win.prio < o_running_prio))
		else $error("preempt flag wrong");
	chk_fixed_prio: assert property (
		o_win.valid && o_win.vector == exc_pkg::EXC_NMI
		|-> o_win.prio == exc_pkg::PRI_NMI) else $error("fixed prio wrong");
	chk_prio_range: assert property (
		o_win.valid |-> o_win.prio >= -5'sd2 && o_win.prio <= 5'sd7)
		else $error("winner prio out of range");
	// Main scenarios
	cover property (o_win.valid && o_win.preempt);
	cover property (i_take);
	cover property (vb != 32'h0);
endmodule
bind exception_priority_vectoring exception_priority_vectoring_monitor
	exception_priority_vectoring_monitor_inst (.i_clk, .i_rst, .i_take,
	.i_irq, .o_irq_pend, .o_vector_base_offset_reg, .o_win, .o_running_prio);

// ===== bench/core_model.sv
// Core model: takes preempting winners, returns on request.
// Assumes the arbiter's registered winner output.
`timescale 1ns/100ps
module core_model (
	input  wire logic             i_clk, i_auto, i_ret,
	input  wire exc_pkg::winner_t i_win,
	output logic                  o_take, o_done,
	output logic [31:0]           o_handler
);
	logic [1:0] gap_q = 2'h0;
	// One take per winner; gap lets the registered winner catch up
	always_ff @(posedge i_clk) begin
		o_take <= i_auto && i_win.valid && i_win.preempt &&
			!o_take && gap_q == 2'h0;
		gap_q <= o_take ? 2'h3 : gap_q - {1'b0, gap_q != 2'h0};
		o_done <= i_ret;
		if (o_take) o_handler <= {i_win.addr[31:1], 1'b1};
	end
endmodule

// ===== bench/exception_priority_vectoring_tb.sv
// Testbench for exception arbitration and vectoring.
// Core side is modelled; peripheral lines are driven directly.
`timescale 1ns/100ps
module exception_priority_vectoring_tb;
	logic clk = 0, rst = 1, pwe = 0, bwe = 0, priv = 0;
	logic au = 0, ret = 0, take, done;
	logic [43:0] irq = 0, en = '1, pend;
	logic [5:0] idx = 0;
	logic [2:0] pv = 0;
	logic [31:0] bv = 0, base, hnd;
	exc_pkg::sys_pend_t sreq = '0;
	exc_pkg::winner_t win;
	logic signed [4:0] run;
	int num_errors = 0, tests_run = 0;
	int lines[7] = '{0, 7, 14, 18, 32, 35, 43};
	always #2.5 clk = ~clk;
	exception_priority_vectoring exception_priority_vectoring_inst (.i_clk(clk),
		.i_rst(rst), .i_irq(irq), .i_irq_en(en), .i_sys_req(sreq), .i_prio_we(pwe),
		.i_prio_idx(idx), .i_prio_val(pv), .i_base_we(bwe), .i_base_priv(priv),
		.i_base_val(bv), .i_take(take), .i_done(done), .o_irq_pend(pend),
		.o_vector_base_offset_reg(base), .o_win(win), .o_running_prio(run));
	core_model core_model_inst (.i_clk(clk), .i_auto(au), .i_ret(ret),
		.i_win(win), .o_take(take), .o_done(done), .o_handler(hnd));
	// Helpers
	task chk(string w, logic [43:0] g, logic [43:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", w, e, g);
		end
	endtask
	task cyc(int n); repeat (n) @(posedge clk); endtask
	task pulse(int n); @(posedge clk); irq[n] <= 1; cyc(1);
		irq[n] <= 0; cyc(2); #1; endtask
	task wp(int i, int v); @(posedge clk); pwe <= 1; idx <= i; pv <= v;
		cyc(1); pwe <= 0; endtask
	task wb(bit p, logic [31:0] v); @(posedge clk);
		bwe <= 1; priv <= p; bv <= v; cyc(1);
		bwe <= 0; cyc(2); #1; endtask
	task ret1; cyc(3); ret <= 1; cyc(1); ret <= 0; cyc(3); endtask
	// One line through to its handler address
	task vec(int n, logic [31:0] b);
		pulse(n);
		chk("vector", win.vector, 16 + n);
		chk("addr", win.addr, b + 4 * (16 + n));
		chk("prio", win.prio, 0);
		cyc(3); #1;
		chk("cleared", pend[n], 0);
		chk("handler", hnd, b + 4 * (16 + n) + 1);
		ret1;
	endtask
	task s_map; au <= 1; foreach (lines[i]) vec(lines[i], 0); endtask
	task s_rsv; au <= 0;
		foreach (lines[i]) pulse(lines[i] > 20 ? 33 + i : 8 + i);
		chk("rsv", pend, 0);
	endtask
	task s_base; au <= 1;
		wb(1, 32'h2000_01A4); chk("base", base, 32'h2000_0100);
		wb(0, 32'h1000_0000); wb(1, 32'h4000_0000); wb(1, 32'h0);
		chk("base", base, 32'h2000_0100);
		vec(5, 32'h2000_0100);
		rst <= 1; cyc(2); rst <= 0; cyc(1); #1;
		chk("base", base, 0);
	endtask
	task s_prio; au <= 0; wp(16, 5); wp(17, 2);
		@(posedge clk); irq[1:0] <= 2'h3; cyc(1); irq[1:0] <= 0; cyc(2); #1;
		chk("vector", win.vector, 17);
		wp(17, 5); cyc(2); #1;
		chk("vector", win.vector, 16);
		au <= 1; cyc(6); #1;
		chk("run", run, 5);
		chk("preempt", win.preempt, 0);
		chk("pend", pend[1], 1);
		wp(18, 4); pulse(2); cyc(4); #1;
		chk("run", run, 4);
		@(posedge clk); sreq.nmi <= 1; cyc(1); sreq.nmi <= 0; cyc(6); #1;
		chk("run", run, -2);
	endtask
	// Verdict
	task end_sim;
		$display("Checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		end_sim;
	end
	initial begin
		cyc(16); rst <= 0; cyc(1); #1;
		chk("base", base, 0);
		chk("run", run, 8);
		s_map; s_rsv; s_base; s_prio;
		end_sim;
	end
endmodule
